// ---- boot_bus_model.sv ----
// Boot memory and bus arbiter on the far side of the boot controller.
`timescale 1ns/1ps
module boot_bus_model
  import boot_ctrl_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic BUS_REQUEST,
  input wire logic BOOT_MEMORY_SELECT_N,
  input wire logic [boot_ctrl_pkg::ADDR_W-1:0] ADDRESS,
  input wire logic SLOW,
  output logic BUS_GRANT,
  output logic [boot_ctrl_pkg::DATA_W-1:0] READ_DATA
);
  // --------
  // Model
  // --------
  logic [1:0] hold;
  logic [DATA_W-1:0] last;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      hold <= 2'h0;
      BUS_GRANT <= 1'b0;
    end else if (!BUS_REQUEST) begin
      hold <= 2'h0;
      BUS_GRANT <= 1'b0;
    end else if (hold >= (SLOW ? 2'h3 : 2'h0)) begin
      BUS_GRANT <= 1'b1;
    end else begin
      hold <= hold + 2'h1;
    end
  end
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      last <= 32'h0000_0000;
    end else begin
      last <= READ_DATA;
    end
  end
  // A deselected memory shows a changing pattern, not the last word.
  assign READ_DATA = BOOT_MEMORY_SELECT_N ? ~last : 32'hC3A5_0000 ^ ADDRESS;
endmodule

// ---- boot_ctrl.sv ----
// Boot controller: vector table placement and multiprocessor boot sequence.
`timescale 1ns/1ps
module boot_ctrl #(
  parameter int WORDS = boot_ctrl_pkg::BOOT_WORDS,
  parameter int PEERS = 6
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic EPROM_BOOT_STRAP,
  input wire logic LINK_BOOT_STRAP,
  input wire logic BOOT_MEMORY_SELECT_STRAP,
  input wire logic SERIAL_BOOT_STRAP,
  input wire logic [boot_ctrl_pkg::PROC_ID_W-1:0] PROC_ID,
  input wire logic SEQUENTIAL_BOOT,
  input wire logic LAST_IN_CHAIN,
  input wire logic [boot_ctrl_pkg::PROC_ID_W-1:0] PEER_COUNT,
  input wire logic INTERNAL_VECTOR_TABLE_SELECT_WR,
  input wire logic INTERNAL_VECTOR_TABLE_SELECT_IN,
  output logic INTERNAL_VECTOR_TABLE_SELECT,
  output logic VECTOR_TABLE_INTERNAL,
  output logic [boot_ctrl_pkg::ADDR_W-1:0] VECTOR_TABLE_BASE,
  output boot_ctrl_pkg::boot_mode_t BOOT_MODE,
  output logic ID_VALID,
  output logic BUS_REQUEST,
  input wire logic BUS_GRANT,
  input wire logic HOST_LOAD_DONE,
  output logic BOOT_MEMORY_SELECT_N,
  output logic READ_STROBE,
  output logic WRITE_STROBE,
  output logic [boot_ctrl_pkg::ADDR_W-1:0] ADDRESS,
  input wire logic [boot_ctrl_pkg::DATA_W-1:0] READ_DATA,
  output logic [boot_ctrl_pkg::DATA_W-1:0] WRITE_DATA,
  output logic [boot_ctrl_pkg::ADDR_W-1:0] LOAD_ADDRESS,
  output logic [boot_ctrl_pkg::DATA_W-1:0] LOAD_DATA,
  output logic LOAD_WRITE,
  output logic START_ALL,
  input wire logic START_ALL_IN,
  output logic EXECUTE
);
  import boot_ctrl_pkg::*;

  typedef enum logic [2:0] {
    ST_LATCH,
    ST_ARB,
    ST_LOAD,
    ST_RELEASE,
    ST_PEER,
    ST_WAIT,
    ST_RUN
  } state_t;

  state_t state;
  logic latched;
  logic [PROC_ID_W-1:0] peer;
  logic [DATA_W-1:0] peer_word;
  logic in_boot;
  logic more_peers;
  boot_dma_if dma ();

  boot_word_counter #(.WORDS(WORDS)) counter (
    .CLK(CLK),
    .RESET_N(RESET_N),
    .dma(dma)
  );

  function automatic boot_mode_t decode_mode(input logic eb, input logic lb, input logic boot_memory_select,
                                             input logic sb);
    if (eb) begin
      return MODE_EPROM;
    end else if (lb) begin
      return MODE_LINK;
    end else if (sb) begin
      return MODE_SERIAL;
    end else if (boot_memory_select) begin
      return MODE_HOST;
    end else begin
      return MODE_NO_BOOT;
    end
  endfunction

  // ------------------------------------------------------------
  // Strap capture.
  // ------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      latched <= 1'b0;
      BOOT_MODE <= MODE_NO_BOOT;
      ID_VALID <= 1'b0;
    end else if (!latched) begin
      latched <= 1'b1;
      BOOT_MODE <= decode_mode(EPROM_BOOT_STRAP, LINK_BOOT_STRAP, BOOT_MEMORY_SELECT_STRAP,
                               SERIAL_BOOT_STRAP);
      ID_VALID <= (PROC_ID >= PROC_ID_MIN) && (PROC_ID <= PROC_ID_MAX);
    end
  end

  // ------------------------------------------------------------
  // Vector table placement.
  // ------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      INTERNAL_VECTOR_TABLE_SELECT <= 1'b0;
    end else if (INTERNAL_VECTOR_TABLE_SELECT_WR) begin
      INTERNAL_VECTOR_TABLE_SELECT <= INTERNAL_VECTOR_TABLE_SELECT_IN;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      VECTOR_TABLE_INTERNAL <= 1'b0;
      VECTOR_TABLE_BASE <= EXT_TABLE_BASE;
    end else if (BOOT_MODE != MODE_NO_BOOT) begin
      VECTOR_TABLE_INTERNAL <= 1'b1;
      VECTOR_TABLE_BASE <= INT_TABLE_BASE;
    end else begin
      VECTOR_TABLE_INTERNAL <= INTERNAL_VECTOR_TABLE_SELECT;
      VECTOR_TABLE_BASE <= INTERNAL_VECTOR_TABLE_SELECT ? INT_TABLE_BASE : EXT_TABLE_BASE;
    end
  end

  // ------------------------------------------------------------
  // Boot sequence.
  // ------------------------------------------------------------
  assign in_boot = (state == ST_LOAD) || (state == ST_PEER);
  assign more_peers = SEQUENTIAL_BOOT && (PROC_ID == PROC_ID_LEADER) && (peer < PEER_COUNT);
  assign dma.start = (state == ST_ARB && BUS_GRANT && BOOT_MODE == MODE_EPROM) ||
                     (state == ST_RELEASE && more_peers);
  assign dma.beat = in_boot && dma.busy;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state <= ST_LATCH;
      peer <= PROC_ID_MIN;
    end else begin
      unique case (state)
        ST_LATCH: begin
          if (latched) begin
            state <= (BOOT_MODE == MODE_NO_BOOT) ? ST_RUN : ST_ARB;
          end
        end
        ST_ARB: begin
          if (BOOT_MODE == MODE_EPROM) begin
            if (BUS_GRANT) begin
              state <= ST_LOAD;
            end
          end else if (HOST_LOAD_DONE) begin
            state <= ST_WAIT;
          end
        end
        ST_LOAD: begin
          if (dma.done) begin
            state <= ST_RELEASE;
          end
        end
        ST_RELEASE: begin
          if (more_peers) begin
            peer <= peer + PROC_ID_MIN;
            state <= ST_PEER;
          end else if (LAST_IN_CHAIN || SEQUENTIAL_BOOT) begin
            state <= ST_RUN;
          end else begin
            state <= ST_WAIT;
          end
        end
        ST_PEER: begin
          if (dma.done) begin
            state <= ST_RELEASE;
          end
        end
        ST_WAIT: begin
          if (START_ALL_IN) begin
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          state <= ST_RUN;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Bus signals and loaded data.
  // ------------------------------------------------------------
  // The leader keeps the bus between its own stream and the peer streams.
  assign BUS_REQUEST = (state == ST_ARB && BOOT_MODE == MODE_EPROM) || in_boot ||
                       (state == ST_RELEASE && more_peers);
  assign BOOT_MEMORY_SELECT_N = !dma.beat;
  assign READ_STROBE = dma.beat;
  assign ADDRESS = EPROM_BASE + ADDR_W'(dma.index);
  assign peer_word = READ_DATA;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      LOAD_ADDRESS <= INT_LOAD_BASE;
      LOAD_DATA <= 32'h0000_0000;
      LOAD_WRITE <= 1'b0;
      WRITE_DATA <= 32'h0000_0000;
      WRITE_STROBE <= 1'b0;
    end else begin
      LOAD_WRITE <= (state == ST_LOAD) && dma.beat;
      LOAD_ADDRESS <= INT_LOAD_BASE + ADDR_W'(dma.index);
      LOAD_DATA <= READ_DATA;
      WRITE_STROBE <= (state == ST_PEER) && dma.beat;
      WRITE_DATA <= peer_word;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      START_ALL <= 1'b0;
      EXECUTE <= 1'b0;
    end else begin
      START_ALL <= (state == ST_RELEASE) && LAST_IN_CHAIN && !SEQUENTIAL_BOOT;
      EXECUTE <= (state == ST_RUN);
    end
  end
endmodule

// ---- boot_ctrl_pkg.sv ----
// Package with boot mode encodings, boot stream sizes and processor identifier limits.
package boot_ctrl_pkg;

  localparam int BOOT_WORDS = 256;
  localparam int WORD_COUNT_W = 9;
  localparam int PROC_ID_W = 3;
  localparam logic [PROC_ID_W-1:0] PROC_ID_MIN = 3'h1;
  localparam logic [PROC_ID_W-1:0] PROC_ID_MAX = 3'h6;
  localparam logic [PROC_ID_W-1:0] PROC_ID_LEADER = 3'h1;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 32;
  localparam logic [ADDR_W-1:0] INT_TABLE_BASE = 32'h0004_0000;
  localparam logic [ADDR_W-1:0] EXT_TABLE_BASE = 32'h0020_0000;
  localparam logic [ADDR_W-1:0] EPROM_BASE = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] INT_LOAD_BASE = 32'h0004_0000;
  localparam logic [ADDR_W-1:0] MP_SPACE_STRIDE = 32'h0010_0000;
  localparam logic [ADDR_W-1:0] PEER_BUF0_OFFSET = 32'h0000_0000;
  localparam logic [WORD_COUNT_W-1:0] WORD_COUNT_ZERO = 9'h000;
  localparam logic [WORD_COUNT_W-1:0] WORD_COUNT_ONE = 9'h001;
  localparam logic [WORD_COUNT_W-1:0] WORD_COUNT_LAST = 9'h0FF;

  typedef enum logic [2:0] {
    MODE_NO_BOOT,
    MODE_EPROM,
    MODE_HOST,
    MODE_LINK,
    MODE_SERIAL
  } boot_mode_t;

  typedef enum logic [1:0] {
    SRC_EPROM,
    SRC_PEER
  } dma_src_t;

endpackage

// ---- boot_ctrl_props.sv ----
// Checker of the boot controller's port behaviour.
`timescale 1ns/1ps
module boot_ctrl_props
  import boot_ctrl_pkg::*;
#(
  parameter int WORDS = BOOT_WORDS
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic SEQUENTIAL_BOOT,
  input wire logic INTERNAL_VECTOR_TABLE_SELECT_WR,
  input wire logic INTERNAL_VECTOR_TABLE_SELECT_IN,
  input wire logic INTERNAL_VECTOR_TABLE_SELECT,
  input wire logic VECTOR_TABLE_INTERNAL,
  input wire boot_ctrl_pkg::boot_mode_t BOOT_MODE,
  input wire logic BUS_REQUEST,
  input wire logic BUS_GRANT,
  input wire logic BOOT_MEMORY_SELECT_N,
  input wire logic READ_STROBE,
  input wire logic [boot_ctrl_pkg::ADDR_W-1:0] ADDRESS,
  input wire logic EXECUTE
);
  // --------
  // Checks
  // --------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);
  logic [9:0] beats;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      beats <= 10'h000;
    end else begin
      beats <= READ_STROBE ? beats + 10'h001 : 10'h000;
    end
  end
  sequence seq_settled;
    RESET_N [*5];
  endsequence
  sequence seq_first_beat;
    READ_STROBE && !BOOT_MEMORY_SELECT_N && ADDRESS == EPROM_BASE;
  endsequence
  AST_BOOT_INT: assert property ($stable(BOOT_MODE) && BOOT_MODE != MODE_NO_BOOT
    |-> VECTOR_TABLE_INTERNAL) else $error("table not internal");
  AST_NOBOOT_SEL: assert property (BOOT_MODE == MODE_NO_BOOT && $stable(BOOT_MODE)
    && $stable(INTERNAL_VECTOR_TABLE_SELECT)
    |-> VECTOR_TABLE_INTERNAL == INTERNAL_VECTOR_TABLE_SELECT) else $error("table wrong");
  AST_SEL_WRITE: assert property (INTERNAL_VECTOR_TABLE_SELECT_WR
    |=> INTERNAL_VECTOR_TABLE_SELECT == $past(INTERNAL_VECTOR_TABLE_SELECT_IN))
    else $error("select not stored");
  AST_SEL_RESET: assert property ($rose(RESET_N)
    |-> !INTERNAL_VECTOR_TABLE_SELECT) else $error("select not zero");
  AST_MODE_HOLD: assert property (seq_settled |-> $stable(BOOT_MODE))
    else $error("mode changed");
  AST_GRANT_BEAT: assert property (!SEQUENTIAL_BOOT && BUS_REQUEST && BUS_GRANT
    && !READ_STROBE |=> seq_first_beat) else $error("no first beat");
  AST_MASTER_READ: assert property (READ_STROBE
    |-> BUS_GRANT && ADDRESS == EPROM_BASE + 32'(beats)) else $error("read not as master");
  AST_STREAM_LEN: assert property (!SEQUENTIAL_BOOT && $fell(READ_STROBE)
    |-> beats == WORDS) else $error("stream length");
  AST_EXEC_AFTER: assert property ($rose(EXECUTE)
    |-> !BUS_REQUEST && !READ_STROBE ##1 EXECUTE [*8]) else $error("run too early");
endmodule

bind boot_ctrl boot_ctrl_props #(.WORDS(WORDS)) i_props (.CLK(CLK), .RESET_N(RESET_N),
  .SEQUENTIAL_BOOT(SEQUENTIAL_BOOT),
  .INTERNAL_VECTOR_TABLE_SELECT_WR(INTERNAL_VECTOR_TABLE_SELECT_WR),
  .INTERNAL_VECTOR_TABLE_SELECT_IN(INTERNAL_VECTOR_TABLE_SELECT_IN),
  .INTERNAL_VECTOR_TABLE_SELECT(INTERNAL_VECTOR_TABLE_SELECT),
  .VECTOR_TABLE_INTERNAL(VECTOR_TABLE_INTERNAL), .BOOT_MODE(BOOT_MODE),
  .BUS_REQUEST(BUS_REQUEST), .BUS_GRANT(BUS_GRANT), .BOOT_MEMORY_SELECT_N(BOOT_MEMORY_SELECT_N),
  .READ_STROBE(READ_STROBE), .ADDRESS(ADDRESS), .EXECUTE(EXECUTE));

// ---- boot_ctrl_test.sv ----
// Self-checking testbench of the boot controller.
`timescale 1ns/1ps
module boot_ctrl_test;
  import boot_ctrl_pkg::*;
  logic clk, rst_n = 0, eb = 0, lb = 0, bm = 0, sb = 0, sq = 0, lst = 0;
  logic wr = 0, wi = 0, go = 0, sel, vti, idv, req, gnt, bmsn, ws, lwr, sa, ex;
  logic [2:0] pid = 0;
  logic [31:0] vtb, adr, rdat, ldat, wdat, ladr;
  logic [7:0] rnd = 8'h56;
  boot_mode_t md;
  int bad_count, compares, wbeats, starts;
  logic [31:0] exp_q[$];
  logic [31:0] exp_a[$];
  logic [31:0] exp_w[$];
  // --------
  // Bench
  // --------
  boot_ctrl i_dut (.CLK(clk), .RESET_N(rst_n), .EPROM_BOOT_STRAP(eb), .LINK_BOOT_STRAP(lb),
    .BOOT_MEMORY_SELECT_STRAP(bm), .SERIAL_BOOT_STRAP(sb), .PROC_ID(pid), .SEQUENTIAL_BOOT(sq),
    .LAST_IN_CHAIN(lst), .PEER_COUNT(3'h2), .INTERNAL_VECTOR_TABLE_SELECT_WR(wr),
    .INTERNAL_VECTOR_TABLE_SELECT_IN(wi), .INTERNAL_VECTOR_TABLE_SELECT(sel),
    .VECTOR_TABLE_INTERNAL(vti), .VECTOR_TABLE_BASE(vtb), .BOOT_MODE(md), .ID_VALID(idv),
    .BUS_REQUEST(req), .BUS_GRANT(gnt), .HOST_LOAD_DONE(go), .BOOT_MEMORY_SELECT_N(bmsn),
    .READ_STROBE(), .WRITE_STROBE(ws), .ADDRESS(adr), .READ_DATA(rdat), .WRITE_DATA(wdat),
    .LOAD_ADDRESS(ladr), .LOAD_DATA(ldat), .LOAD_WRITE(lwr), .START_ALL(sa), .START_ALL_IN(go),
    .EXECUTE(ex));
  boot_bus_model i_mem (.CLK(clk), .RESET_N(rst_n), .BUS_REQUEST(req),
    .BOOT_MEMORY_SELECT_N(bmsn), .ADDRESS(adr), .SLOW(pid[0]), .BUS_GRANT(gnt), .READ_DATA(rdat));
  function automatic logic [7:0] lfsr_next(logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(string what, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic run_case(logic [3:0] st, boot_mode_t m, logic [2:0] id, logic l, logic v);
    logic t;
    logic q;
    int n;
    t = (st == 4'h0) ? v : 1'b1;
    q = st[3] && id == 3'h1;
    @(posedge clk);
    rst_n <= 1'b0;
    {eb, lb, bm, sb} <= st;
    pid <= id;
    lst <= l;
    sq <= q;
    go <= 1'b0;
    wbeats = 0;
    starts = 0;
    for (n = 0; st[3] && n < BOOT_WORDS; n++) begin
      exp_q.push_back(32'hC3A5_0000 ^ n);
      exp_a.push_back(INT_LOAD_BASE + n);
      if (q) exp_w.push_back(32'hC3A5_0000 ^ n);
    end
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk("select", 0, sel);
    eb <= ~st[3];
    wr <= 1'b1;
    wi <= v;
    @(posedge clk);
    wr <= 1'b0;
    repeat (2) @(posedge clk);
    chk("select", v, sel);
    chk("internal", t, vti);
    chk("base", t ? INT_TABLE_BASE : EXT_TABLE_BASE, vtb);
    chk("id valid", id >= PROC_ID_MIN && id <= PROC_ID_MAX, idv);
    if (st != 4'h0) begin
      for (n = 0; n < 2000 && exp_q.size() > 0; n++) @(posedge clk);
      repeat (20) @(posedge clk);
      if (!q) chk("early run", st[3] && l, ex);
      go <= 1'b1;
      for (n = 0; n < 2000 && ex !== 1'b1; n++) @(posedge clk);
      chk("run", 1, ex);
      if (!q) chk("start pulses", st[3] && l, starts);
      if (q) chk("peer words", BOOT_WORDS, wbeats);
      chk("words left", 0, exp_q.size() + exp_a.size() + exp_w.size());
    end
    chk("mode", m, md);
  endtask
  always @(posedge clk) begin
    if (lwr === 1'b1) begin
      chk("load word", exp_q.size() > 0 ? exp_q.pop_front() : 'x, ldat);
      chk("load addr", exp_a.size() > 0 ? exp_a.pop_front() : 'x, ladr);
    end
    if (ws === 1'b1) begin
      wbeats++;
      chk("peer word", exp_w.size() > 0 ? exp_w.pop_front() : 'x, wdat);
    end
    if (sa === 1'b1) starts++;
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #400000;
    bad_count++;
    wrap_up();
  end
  initial begin
    repeat (3) begin
      rnd = lfsr_next(rnd);
      run_case(4'h0, MODE_NO_BOOT, rnd[2:0], 1'b0, rnd[7]);
    end
    run_case(4'h8, MODE_EPROM, 3'h2, 1'b1, 1'b1);
    run_case(4'h8, MODE_EPROM, 3'h3, 1'b0, 1'b0);
    run_case(4'h8, MODE_EPROM, 3'h1, 1'b0, 1'b0);
    run_case(4'h2, MODE_HOST, 3'h4, 1'b0, 1'b1);
    run_case(4'h4, MODE_LINK, 3'h5, 1'b0, 1'b1);
    run_case(4'h1, MODE_SERIAL, 3'h6, 1'b0, 1'b0);
    wrap_up();
  end
endmodule

// ---- boot_dma_if.sv ----
// Interface carrying one boot stream transfer between the sequencer and the word counter.
`timescale 1ns/1ps
interface boot_dma_if;
  logic start;
  logic beat;
  logic done;
  logic busy;
  logic [boot_ctrl_pkg::WORD_COUNT_W-1:0] index;
  modport ctrl (output start, output beat, input done, input busy, input index);
  modport counter (input start, input beat, output done, output busy, output index);
endinterface

// ---- boot_word_counter.sv ----
// Counter that walks through one boot stream of fixed word count.
`timescale 1ns/1ps
module boot_word_counter #(
  parameter int WORDS = boot_ctrl_pkg::BOOT_WORDS
) (
  input wire logic CLK,
  input wire logic RESET_N,
  boot_dma_if.counter dma
);
  import boot_ctrl_pkg::*;

  logic [WORD_COUNT_W-1:0] count;
  logic busy;

  // ------------------------------------------------------------
  // Word count.
  // ------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      count <= WORD_COUNT_ZERO;
      busy <= 1'b0;
    end else if (dma.start && !busy) begin
      count <= WORD_COUNT_ZERO;
      busy <= 1'b1;
    end else if (busy && dma.beat) begin
      count <= count + WORD_COUNT_ONE;
      if (count == WORD_COUNT_W'(WORDS - 1)) begin
        busy <= 1'b0;
      end
    end
  end

  assign dma.busy = busy;
  assign dma.index = count;
  assign dma.done = busy && dma.beat && (count == WORD_COUNT_W'(WORDS - 1));
endmodule
